// ===== rtl/isr_cfg.svh
// isr_cfg.svh: bit positions, masks, reset values and widths for the status block
// assumes: included by name from rtl/, definitions only
`ifndef ISR_CFG_SVH
`define ISR_CFG_SVH

// summary status byte bit positions
`define ISR_SB_ERRQ     2
`define ISR_SB_QSUM     3
`define ISR_SB_OUTQ     4
`define ISR_SB_ESUM     5
`define ISR_SB_REQ      6
`define ISR_SB_OSUM     7
// bits 0 and 1 unused; bit 6 never feeds the master summary
`define ISR_SB_USED     8'hfc
`define ISR_SB_UNUSED   8'h03
`define ISR_SRE_CARE    8'hbc

// standard event flag bit positions
`define ISR_ES_DONE     0
`define ISR_ES_QFLT     2
`define ISR_ES_IFLT     3
`define ISR_ES_XFLT     4
`define ISR_ES_CFLT     5
`define ISR_ES_PWR      7
`define ISR_ES_USED     8'hbd
// power-up flag is the only flag standing after reset
`define ISR_ES_RST      8'h80

// operation and questionable groups
`define ISR_GW          16
`define ISR_OP_USED     16'h1a30
`define ISR_QS_USED     16'h7fff
`define ISR_OP_PTR_RST  16'h7fff
`define ISR_OP_NTR_RST  16'h0000
`define ISR_QS_PTR      16'h7fff
`define ISR_GRP_ZERO    16'h0000
`define ISR_MASK_RST    8'h00
`define ISR_BYTE_ZERO   8'h00

// measurement counting
`define ISR_CNT_ONE     16'h0001
`define ISR_CNT_ZERO    16'h0000
`define ISR_DONE_TRUE   16'h0001

`endif

// ===== rtl/isr_pkg.sv
// isr_pkg: command codes and carrier structs for the status block
// assumes: nothing beyond the constants header
`default_nettype none
package isr_pkg;

   typedef enum logic [4:0] {
      isr_nop, isr_spoll, isr_stb_q, isr_esr_q, isr_sre_w, isr_sre_q,
      isr_ese_w, isr_ese_q, isr_cls, isr_done_w, isr_done_q, isr_init,
      isr_op_evt_q, isr_op_cond_q, isr_op_en_w, isr_op_en_q,
      isr_op_ptr_w, isr_op_ptr_q, isr_op_ntr_w, isr_op_ntr_q,
      isr_qs_evt_q, isr_qs_cond_q, isr_qs_en_w, isr_qs_en_q, isr_preset
   } isr_cmd_e_t;

   typedef struct packed {
      isr_cmd_e_t  code;
      logic [15:0] data;
   } isr_cmd_t;

   typedef struct packed {
      logic query;
      logic instrument;
      logic execution;
      logic command;
   } isr_fault_t;

   typedef struct packed {
      logic        valid;
      logic [15:0] data;
   } isr_rsp_t;

endpackage : isr_pkg
`default_nettype wire

// ===== rtl/isr_top.sv
// isr_top: instrument status reporting, status byte, event flags, groups, service request
// assumes: commands already parsed into codes, one per enabled cycle; inputs synchronous to clk_in
//
// Functional notes
// - status bit 2 follows error queue nonempty
// - status bit 3 is enabled questionable summary
// - status bit 4 follows output queue nonempty
// - status bit 5 is enabled standard event summary
// - status bit 7 is enabled operation summary
// - serial poll returns request flag, then clears it
// - status query returns master summary in bit 6
// - service enable mask written and read by command
// - zero or power-on clears mask, blocking requests
// - event query and clear-status clear standard flags
// - completion command sets bit 0 when pending ends
// - pending ends after one or averaged measurements
// - completion query leaves bit 0 untouched
// - query faults set standard bit 2
// - instrument faults set standard bit 3
// - execution faults set standard bit 4
// - command faults set standard bit 5
// - power-on sets standard bit 7
// - standard bits 1,6 and status 0,1 unused
// - standard enable mask, cleared by zero or power-on
// - operation and questionable groups with filters, events, enables
// - status byte changes only with structures; clear-status clears
`include "isr_cfg.svh"
`default_nettype none
module isr_top (
   // clock, reset, enable
   input  wire logic               clk_in,
   input  wire logic               nrst_in,
   input  wire logic               ce_in,
   // host command port
   input  wire logic               cmd_valid_in,
   input  wire isr_pkg::isr_cmd_t  cmd_in,
   output var isr_pkg::isr_rsp_t   rsp_out,
   // instrument state
   input  wire logic               error_queue_nonempty_in,
   input  wire logic               output_queue_nonempty_in,
   input  wire isr_pkg::isr_fault_t fault_in,
   input  wire logic               meas_done_in,
   input  wire logic               averaging_on_in,
   input  wire logic [15:0]        averaging_count_in,
   input  wire logic [15:0]        op_cond_in,
   input  wire logic [15:0]        qs_cond_in,
   // summary outputs
   output logic [7:0]              stb_out,
   output logic                    srq_out,
   output logic                    cls_out
);

   // reset release through two flops
   logic rst_meta_r;
   logic rst_n;
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rst_meta_r <= 1'b0;
         rst_n      <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n      <= rst_meta_r;
      end
   end

   function automatic logic is_cmd(input logic v, input isr_pkg::isr_cmd_e_t c,
                                   input isr_pkg::isr_cmd_e_t want);
      is_cmd = v && (c == want);
   endfunction : is_cmd

   // edge filter shared by both groups
   function automatic logic [15:0] edge_hits(input logic [15:0] prev, input logic [15:0] cur,
                                             input logic [15:0] ptr, input logic [15:0] ntr);
      edge_hits = (~prev & cur & ptr) | (prev & ~cur & ntr);
   endfunction : edge_hits

   isr_pkg::isr_cmd_e_t code;
   logic [15:0]         arg;
   assign code = cmd_in.code;
   assign arg  = cmd_in.data;

   logic [7:0]  sre_r;
   logic [7:0]  ese_r;
   logic [7:0]  esr_r;
   logic [15:0] op_ptr_r;
   logic [15:0] op_ntr_r;
   logic [15:0] op_en_r;
   logic [15:0] op_evt_r;
   logic [15:0] op_prev_r;
   logic [15:0] qs_en_r;
   logic [15:0] qs_evt_r;
   logic [15:0] qs_prev_r;
   logic        req_flag_r;
   logic        msum_q_r;
   logic        done_armed_r;
   logic        doneq_wait_r;
   logic        pend_r;
   logic [15:0] meas_cnt_r;

   logic do_cls;
   logic do_preset;
   assign do_cls    = is_cmd(cmd_valid_in, code, isr_pkg::isr_cls);
   assign do_preset = is_cmd(cmd_valid_in, code, isr_pkg::isr_preset);

   // live summary; bit 6 is filled per read type
   logic       op_sum;
   logic       qs_sum;
   logic       es_sum;
   logic [7:0] sb_live;
   logic       msum;
   assign op_sum = |(op_evt_r & op_en_r);
   assign qs_sum = |(qs_evt_r & qs_en_r);
   assign es_sum = |(esr_r & ese_r);
   always_comb begin
      sb_live                = `ISR_BYTE_ZERO;
      sb_live[`ISR_SB_ERRQ]  = error_queue_nonempty_in;
      sb_live[`ISR_SB_QSUM]  = qs_sum;
      sb_live[`ISR_SB_OUTQ]  = output_queue_nonempty_in;
      sb_live[`ISR_SB_ESUM]  = es_sum;
      sb_live[`ISR_SB_OSUM]  = op_sum;
      sb_live                = sb_live & `ISR_SB_USED;
   end
   assign msum = |(sb_live & sre_r & `ISR_SRE_CARE);

   // host-written masks
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         sre_r <= `ISR_MASK_RST;
         ese_r <= `ISR_MASK_RST;
      end else if (ce_in) begin
         if (is_cmd(cmd_valid_in, code, isr_pkg::isr_sre_w))
            sre_r <= arg[7:0];
         if (is_cmd(cmd_valid_in, code, isr_pkg::isr_ese_w))
            ese_r <= arg[7:0];
      end
   end

   // standard event flags: a set in the clearing cycle survives
   logic [7:0] esr_set;
   logic       done_fire;
   assign done_fire = done_armed_r && !pend_r;
   always_comb begin
      esr_set               = `ISR_BYTE_ZERO;
      esr_set[`ISR_ES_DONE] = done_fire;
      esr_set[`ISR_ES_QFLT] = fault_in.query;
      esr_set[`ISR_ES_IFLT] = fault_in.instrument;
      esr_set[`ISR_ES_XFLT] = fault_in.execution;
      esr_set[`ISR_ES_CFLT] = fault_in.command;
   end
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         esr_r <= `ISR_ES_RST;
      end else if (ce_in) begin
         if (do_cls || is_cmd(cmd_valid_in, code, isr_pkg::isr_esr_q))
            esr_r <= esr_set & `ISR_ES_USED;
         else
            esr_r <= (esr_r | esr_set) & `ISR_ES_USED;
      end
   end

   // pending measurement tracking
   logic [15:0] meas_target;
   assign meas_target = (averaging_on_in && averaging_count_in != `ISR_CNT_ZERO) ?
                        averaging_count_in : `ISR_CNT_ONE;
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         pend_r     <= 1'b0;
         meas_cnt_r <= `ISR_CNT_ZERO;
      end else if (ce_in) begin
         if (is_cmd(cmd_valid_in, code, isr_pkg::isr_init)) begin
            pend_r     <= 1'b1;
            meas_cnt_r <= `ISR_CNT_ZERO;
         end else if (pend_r && meas_done_in) begin
            meas_cnt_r <= meas_cnt_r + `ISR_CNT_ONE;
            if (meas_cnt_r + `ISR_CNT_ONE >= meas_target)
               pend_r <= 1'b0;
         end
      end
   end

   // completion arming; the query form never touches the flag
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         done_armed_r <= 1'b0;
         doneq_wait_r <= 1'b0;
      end else if (ce_in) begin
         if (is_cmd(cmd_valid_in, code, isr_pkg::isr_done_w))
            done_armed_r <= 1'b1;
         else if (done_fire)
            done_armed_r <= 1'b0;
         if (is_cmd(cmd_valid_in, code, isr_pkg::isr_done_q) && pend_r)
            doneq_wait_r <= 1'b1;
         else if (!pend_r)
            doneq_wait_r <= 1'b0;
      end
   end

   // operation and questionable groups
   logic [15:0] op_hits;
   logic [15:0] qs_hits;
   logic        op_clr;
   logic        qs_clr;
   assign op_hits = edge_hits(op_prev_r, op_cond_in, op_ptr_r, op_ntr_r) & `ISR_OP_USED;
   assign qs_hits = edge_hits(qs_prev_r, qs_cond_in, `ISR_QS_PTR, `ISR_GRP_ZERO) & `ISR_QS_USED;
   assign op_clr  = do_cls || is_cmd(cmd_valid_in, code, isr_pkg::isr_op_evt_q);
   assign qs_clr  = do_cls || is_cmd(cmd_valid_in, code, isr_pkg::isr_qs_evt_q);
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         op_prev_r <= `ISR_GRP_ZERO;
         qs_prev_r <= `ISR_GRP_ZERO;
         op_evt_r  <= `ISR_GRP_ZERO;
         qs_evt_r  <= `ISR_GRP_ZERO;
      end else if (ce_in) begin
         op_prev_r <= op_cond_in;
         qs_prev_r <= qs_cond_in;
         op_evt_r  <= (op_clr ? `ISR_GRP_ZERO : op_evt_r) | op_hits;
         qs_evt_r  <= (qs_clr ? `ISR_GRP_ZERO : qs_evt_r) | qs_hits;
      end
   end
   // filters survive clear-status; preset restores defaults
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         op_ptr_r <= `ISR_OP_PTR_RST;
         op_ntr_r <= `ISR_OP_NTR_RST;
         op_en_r  <= `ISR_GRP_ZERO;
         qs_en_r  <= `ISR_GRP_ZERO;
      end else if (ce_in) begin
         if (do_preset) begin
            op_ptr_r <= `ISR_OP_PTR_RST;
            op_ntr_r <= `ISR_OP_NTR_RST;
            op_en_r  <= `ISR_GRP_ZERO;
            qs_en_r  <= `ISR_GRP_ZERO;
         end else if (cmd_valid_in) begin
            if (code == isr_pkg::isr_op_ptr_w) op_ptr_r <= arg & `ISR_OP_USED;
            if (code == isr_pkg::isr_op_ntr_w) op_ntr_r <= arg & `ISR_OP_USED;
            if (code == isr_pkg::isr_op_en_w)  op_en_r  <= arg & `ISR_OP_USED;
            if (code == isr_pkg::isr_qs_en_w)  qs_en_r  <= arg & `ISR_QS_USED;
         end
      end
   end

   // request flag: raised on a new reason, dropped by a poll or when the reason goes
   logic spoll;
   logic req_flag_nxt;
   assign spoll        = is_cmd(cmd_valid_in, code, isr_pkg::isr_spoll);
   assign req_flag_nxt = (msum && !msum_q_r) || (req_flag_r && msum && !spoll);
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         req_flag_r <= 1'b0;
         msum_q_r   <= 1'b0;
         srq_out    <= 1'b0;
      end else if (ce_in) begin
         req_flag_r <= req_flag_nxt;
         msum_q_r   <= msum;
         srq_out    <= req_flag_nxt;
      end
   end

   // registered status byte copy, bit 6 shows master summary
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         stb_out <= `ISR_BYTE_ZERO;
         cls_out <= 1'b0;
      end else if (ce_in) begin
         stb_out              <= sb_live;
         stb_out[`ISR_SB_REQ] <= msum;
         cls_out              <= do_cls;
      end
   end

   // answers, one cycle after the command; a completion query waits while pending
   isr_pkg::isr_rsp_t rsp_nxt;
   always_comb begin
      rsp_nxt.valid = cmd_valid_in;
      rsp_nxt.data  = `ISR_GRP_ZERO;
      unique case (code)
         isr_pkg::isr_spoll: begin
            rsp_nxt.data[7:0]        = sb_live;
            rsp_nxt.data[`ISR_SB_REQ] = req_flag_r;
         end
         isr_pkg::isr_stb_q: begin
            rsp_nxt.data[7:0]        = sb_live;
            rsp_nxt.data[`ISR_SB_REQ] = msum;
         end
         isr_pkg::isr_esr_q:     rsp_nxt.data[7:0] = esr_r & `ISR_ES_USED;
         isr_pkg::isr_sre_q:     rsp_nxt.data[7:0] = sre_r;
         isr_pkg::isr_ese_q:     rsp_nxt.data[7:0] = ese_r;
         isr_pkg::isr_op_evt_q:  rsp_nxt.data = op_evt_r;
         isr_pkg::isr_op_cond_q: rsp_nxt.data = op_cond_in & `ISR_OP_USED;
         isr_pkg::isr_op_en_q:   rsp_nxt.data = op_en_r;
         isr_pkg::isr_op_ptr_q:  rsp_nxt.data = op_ptr_r;
         isr_pkg::isr_op_ntr_q:  rsp_nxt.data = op_ntr_r;
         isr_pkg::isr_qs_evt_q:  rsp_nxt.data = qs_evt_r;
         isr_pkg::isr_qs_cond_q: rsp_nxt.data = qs_cond_in & `ISR_QS_USED;
         isr_pkg::isr_qs_en_q:   rsp_nxt.data = qs_en_r;
         isr_pkg::isr_done_q: begin
            // held back until measurements finish
            rsp_nxt.valid = cmd_valid_in && !pend_r;
            rsp_nxt.data  = `ISR_DONE_TRUE;
         end
         default: begin
            rsp_nxt.valid = 1'b0;
         end
      endcase
      if (doneq_wait_r && !pend_r) begin
         rsp_nxt.valid = 1'b1;
         rsp_nxt.data  = `ISR_DONE_TRUE;
      end
   end
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         rsp_out <= '0;
      end else if (ce_in) begin
         rsp_out <= rsp_nxt;
      end
   end

   // checks, sampled on enabled edges only
   default clocking ck @(posedge clk_in iff ce_in); endclocking
   default disable iff (!rst_n);

   a_errq_tracks: assert property (error_queue_nonempty_in |=> stb_out[`ISR_SB_ERRQ])
      else $error("error queue bit not set");
   a_qsum_summary: assert property (qs_sum |=> stb_out[`ISR_SB_QSUM])
      else $error("questionable summary missing");
   a_outq_tracks: assert property (!output_queue_nonempty_in |=> !stb_out[`ISR_SB_OUTQ])
      else $error("output queue bit stuck");
   a_esum_summary: assert property ((|(esr_r & ese_r)) |=> stb_out[`ISR_SB_ESUM])
      else $error("standard summary missing");
   a_osum_summary: assert property (!op_sum |=> !stb_out[`ISR_SB_OSUM])
      else $error("operation summary stuck");
   a_spoll_answer: assert property (spoll |=> rsp_out.valid && rsp_out.data[`ISR_SB_REQ] == $past(srq_out))
      else $error("poll answer wrong");
   a_spoll_clears: assert property (spoll && msum_q_r |=> !srq_out)
      else $error("poll did not drop request");
   a_stbq_master: assert property (is_cmd(cmd_valid_in, code, isr_pkg::isr_stb_q)
                                   |=> rsp_out.data[`ISR_SB_REQ] == $past(msum))
      else $error("status query bit 6 wrong");
   a_sre_blocks: assert property (sre_r == `ISR_MASK_RST |-> !msum ##1 !srq_out)
      else $error("request with cleared mask");
   a_esr_clear: assert property (is_cmd(cmd_valid_in, code, isr_pkg::isr_esr_q) && esr_set == `ISR_BYTE_ZERO
                                 |=> esr_r == `ISR_BYTE_ZERO)
      else $error("flags not cleared on read");
   a_done_sets: assert property (done_armed_r && !pend_r |=> esr_r[`ISR_ES_DONE])
      else $error("completion flag missed");
   a_doneq_keep: assert property (!done_armed_r && !is_cmd(cmd_valid_in, code, isr_pkg::isr_done_w)
                                  |=> !esr_r[`ISR_ES_DONE] || $past(esr_r[`ISR_ES_DONE]))
      else $error("completion flag set without command");
   a_unused_zero: assert property ((esr_r & ~`ISR_ES_USED) == `ISR_BYTE_ZERO
                                   && (stb_out & `ISR_SB_UNUSED) == `ISR_BYTE_ZERO)
      else $error("unused bit set");

endmodule : isr_top
`default_nettype wire

// ===== tb/isr_host_model.sv
// isr_host_model: host side of the command port, issues commands and collects answers
// assumes: clk_in is the block clock; answers come back as a one-cycle valid pulse on rsp_in
`default_nettype none
module isr_host_model (
   // clock
   input  wire logic              clk_in,
   // command port
   output var  logic              cmd_valid_out,
   output var  isr_pkg::isr_cmd_t cmd_out,
   input  wire isr_pkg::isr_rsp_t rsp_in
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      cmd_valid_out = 1'b0;
      cmd_out       = '{code: isr_pkg::isr_nop, data: 16'h0000};
   end

   // one command per call, held across one enabled edge, then released
   task automatic send(input isr_pkg::isr_cmd_e_t code, input logic [15:0] data);
      @(negedge clk_in);
      cmd_out.code  = code;
      cmd_out.data  = data;
      cmd_valid_out = 1'b1;
      @(negedge clk_in);
      cmd_valid_out = 1'b0;
      // stale word toggled so a late sample never sees the old value
      cmd_out.data  = ~cmd_out.data;
   endtask : send

   // no answer within the window leaves data unknown, so the caller's compare fails
   task automatic ask(input isr_pkg::isr_cmd_e_t code, output logic [15:0] data);
      int n;
      data = 'x;
      send(code, 16'h0000);
      // a prompt answer already stands when send returns, so look before waiting
      for (n = 0; n < 40; n++) begin
         if (rsp_in.valid === 1'b1) begin
            data = rsp_in.data;
            break;
         end
         @(negedge clk_in);
      end
   endtask : ask
endmodule : isr_host_model
`default_nettype wire

// ===== tb/testbench.sv
// testbench: self-checking bench for isr_top, host model on the command port
// assumes: package, design and tb/isr_host_model.sv compiled before this file
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TIMEOUT_CYCLES = 5000;
   localparam logic [7:0] FAULT_W [4] = '{8'h04, 8'h08, 8'h10, 8'h20};

   logic                clk = 1'b0;
   logic                nrst = 1'b0;
   logic                cmd_valid;
   isr_pkg::isr_cmd_t   cmd;
   isr_pkg::isr_rsp_t   rsp;
   logic                eq = 1'b0;
   logic                oq = 1'b0;
   isr_pkg::isr_fault_t fault = '0;
   logic                meas = 1'b0;
   logic                avg_on = 1'b0;
   logic [15:0]         avg_cnt = 16'h0001;
   logic [15:0]         op_cond = 16'h0000;
   logic [15:0]         qs_cond = 16'h0000;
   logic [7:0]          stb;
   logic                srq;
   logic                cls;
   logic [15:0]         d;
   int                  errors = 0;
   int                  checks = 0;
   int                  cycles = 0;
   int                  cls_cnt = 0;

   always #25 clk = ~clk;

   isr_top isr_top_inst (
      .clk_in(clk), .nrst_in(nrst), .ce_in(1'b1), .cmd_valid_in(cmd_valid), .cmd_in(cmd),
      .rsp_out(rsp), .error_queue_nonempty_in(eq), .output_queue_nonempty_in(oq),
      .fault_in(fault), .meas_done_in(meas), .averaging_on_in(avg_on),
      .averaging_count_in(avg_cnt), .op_cond_in(op_cond), .qs_cond_in(qs_cond),
      .stb_out(stb), .srq_out(srq), .cls_out(cls)
   );

   isr_host_model isr_host_model_inst (
      .clk_in(clk), .cmd_valid_out(cmd_valid), .cmd_out(cmd), .rsp_in(rsp)
   );

   task automatic results();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : results

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic idle(input int n);
      repeat (n) @(negedge clk);
   endtask : idle

   task automatic pulse_meas(input int n);
      repeat (n) begin
         @(negedge clk);
         meas = 1'b1;
         @(negedge clk);
         meas = 1'b0;
      end
   endtask : pulse_meas

   always @(negedge clk) begin
      cls_cnt += int'(cls === 1'b1);
      cycles++;
      // a hang is cut short here and judged as a failure
      if (cycles == TIMEOUT_CYCLES) begin
         errors++;
         results();
      end
   end

   task automatic t_reset();
      check("stb_reset", 16'(stb), 16'h0000);
      isr_host_model_inst.ask(isr_pkg::isr_esr_q, d);
      check("esr_power_up", 16'(d[7:0]), 16'h0080);
      isr_host_model_inst.ask(isr_pkg::isr_esr_q, d);
      check("esr_cleared", 16'(d[7:0]), 16'h0000);
      isr_host_model_inst.ask(isr_pkg::isr_sre_q, d);
      check("sre_reset", 16'(d[7:0]), 16'h0000);
      isr_host_model_inst.ask(isr_pkg::isr_ese_q, d);
      check("ese_reset", 16'(d[7:0]), 16'h0000);
   endtask : t_reset

   task automatic t_queues();
      eq = 1'b1;
      idle(3);
      check("stb_eav_set", 16'(stb[2]), 16'h0001);
      eq = 1'b0;
      oq = 1'b1;
      idle(3);
      check("stb_eav_clr", 16'(stb[2]), 16'h0000);
      check("stb_mav_set", 16'(stb[4]), 16'h0001);
      check("stb_unused", 16'(stb[1:0]), 16'h0000);
      isr_host_model_inst.ask(isr_pkg::isr_stb_q, d);
      check("stb_query", 16'(d[7:0]), 16'h0010);
      oq = 1'b0;
      idle(3);
      check("stb_mav_clr", 16'(stb[4]), 16'h0000);
   endtask : t_queues

   task automatic t_faults();
      for (int i = 0; i < 4; i++) begin
         @(negedge clk);
         fault = isr_pkg::isr_fault_t'(4'b1000 >> i);
         @(negedge clk);
         fault = '0;
         isr_host_model_inst.ask(isr_pkg::isr_esr_q, d);
         check("esr_fault", 16'(d[7:0]), 16'(FAULT_W[i]));
      end
      isr_host_model_inst.send(isr_pkg::isr_ese_w, 16'h0020);
      @(negedge clk);
      fault.command = 1'b1;
      @(negedge clk);
      fault = '0;
      idle(3);
      check("stb_esb_set", 16'(stb[5]), 16'h0001);
      check("srq_masked", 16'(srq), 16'h0000);
      isr_host_model_inst.send(isr_pkg::isr_sre_w, 16'h0020);
      idle(3);
      check("srq_set", 16'(srq), 16'h0001);
      check("stb_master", 16'(stb[6]), 16'h0001);
      isr_host_model_inst.ask(isr_pkg::isr_stb_q, d);
      check("stb_q_master", 16'(d[6]), 16'h0001);
      isr_host_model_inst.ask(isr_pkg::isr_sre_q, d);
      check("sre_readback", 16'(d[7:0]), 16'h0020);
      isr_host_model_inst.ask(isr_pkg::isr_spoll, d);
      check("spoll_rqs", 16'(d[6]), 16'h0001);
      idle(2);
      check("srq_after_poll", 16'(srq), 16'h0000);
      isr_host_model_inst.ask(isr_pkg::isr_esr_q, d);
      check("esr_read", 16'(d[7:0]), 16'h0020);
      idle(3);
      check("stb_esb_clr", 16'(stb[5]), 16'h0000);
      isr_host_model_inst.send(isr_pkg::isr_sre_w, 16'h0000);
      isr_host_model_inst.send(isr_pkg::isr_ese_w, 16'h0000);
   endtask : t_faults

   task automatic t_done();
      isr_host_model_inst.send(isr_pkg::isr_done_w, 16'h0000);
      idle(2);
      isr_host_model_inst.ask(isr_pkg::isr_esr_q, d);
      check("done_idle", 16'(d[7:0]), 16'h0001);
      // averaging on with count 3, then off with a single measurement
      for (int k = 0; k < 2; k++) begin
         avg_on  = (k == 0);
         avg_cnt = 16'h0003;
         isr_host_model_inst.send(isr_pkg::isr_init, 16'h0000);
         isr_host_model_inst.send(isr_pkg::isr_done_w, 16'h0000);
         if (k == 0) begin
            pulse_meas(2);
            idle(3);
            isr_host_model_inst.ask(isr_pkg::isr_esr_q, d);
            check("done_early", 16'(d[7:0]), 16'h0000);
         end
         pulse_meas(1);
         idle(3);
         isr_host_model_inst.ask(isr_pkg::isr_esr_q, d);
         check("done_flag", 16'(d[7:0]), 16'h0001);
      end
      isr_host_model_inst.ask(isr_pkg::isr_done_q, d);
      check("done_query", d, 16'h0001);
      isr_host_model_inst.ask(isr_pkg::isr_esr_q, d);
      check("done_query_esr", 16'(d[7:0]), 16'h0000);
      // query while a measurement is pending: the answer waits, the flag stays clear
      isr_host_model_inst.send(isr_pkg::isr_init, 16'h0000);
      fork
         isr_host_model_inst.ask(isr_pkg::isr_done_q, d);
         pulse_meas(1);
      join
      check("done_query_wait", d, 16'h0001);
      isr_host_model_inst.ask(isr_pkg::isr_esr_q, d);
      check("done_wait_esr", 16'(d[7:0]), 16'h0000);
   endtask : t_done

   task automatic t_groups();
      isr_host_model_inst.ask(isr_pkg::isr_op_ptr_q, d);
      check("op_ptr_reset", d, 16'h7fff);
      isr_host_model_inst.send(isr_pkg::isr_op_en_w, 16'h0010);
      op_cond = 16'h0010;
      idle(3);
      op_cond = 16'h0000;
      idle(3);
      check("stb_osb_sticky", 16'(stb[7]), 16'h0001);
      isr_host_model_inst.ask(isr_pkg::isr_op_evt_q, d);
      check("op_event", d, 16'h0010);
      idle(3);
      check("stb_osb_clr", 16'(stb[7]), 16'h0000);
      isr_host_model_inst.send(isr_pkg::isr_op_ptr_w, 16'h0000);
      isr_host_model_inst.send(isr_pkg::isr_op_ntr_w, 16'h0010);
      op_cond = 16'h0010;
      idle(3);
      op_cond = 16'h0000;
      idle(3);
      isr_host_model_inst.ask(isr_pkg::isr_op_evt_q, d);
      check("op_event_fall", d, 16'h0010);
      isr_host_model_inst.send(isr_pkg::isr_qs_en_w, 16'h0001);
      qs_cond = 16'h0001;
      idle(3);
      check("stb_qsb_set", 16'(stb[3]), 16'h0001);
      cls_cnt = 0;
      isr_host_model_inst.send(isr_pkg::isr_cls, 16'h0000);
      idle(3);
      check("stb_after_cls", 16'(stb), 16'h0000);
      check("cls_pulse", 16'(cls_cnt), 16'h0001);
   endtask : t_groups

   initial begin
      repeat (20) @(posedge clk);
      @(negedge clk);
      nrst = 1'b1;
      idle(5);
      t_reset();
      t_queues();
      t_faults();
      t_done();
      t_groups();
      results();
   end
endmodule : testbench
`default_nettype wire
